// File: hw/aso_pkg.sv
package aso_pkg;

	// ----------------------------------------------------------------
	// Register addresses on the serial control port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam logic [12:0] ADDR_CLOCK_PHASE = 13'h016;
	localparam logic [12:0] ADDR_SERIAL_CTRL = 13'h021;
	localparam logic [12:0] ADDR_TRANSFER = 13'h0ff;
	localparam logic [12:0] ADDR_OVERRIDE = 13'h100;
	localparam logic [12:0] ADDR_IO_PULLDOWN = 13'h101;
	localparam logic [12:0] ADDR_IO_COMMON_MODE = 13'h102;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CLOCK_PHASE = 8'h03;
	localparam logic [7:0] RST_SERIAL_CTRL = 8'h32;
	localparam logic [7:0] RST_OVERRIDE = 8'h00;
	localparam logic [7:0] RST_IO_PULLDOWN = 8'h00;
	localparam logic [7:0] RST_IO_COMMON_MODE = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int IN_PHASE_LSB = 4;
	localparam int IN_PHASE_MSB = 6;
	localparam int OUT_PHASE_LSB = 0;
	localparam int OUT_PHASE_MSB = 3;
	localparam logic [3:0] OUT_PHASE_MAX = 4'hb;
	localparam int WIDTH_LSB = 0;
	localparam int WIDTH_MSB = 1;
	localparam logic [1:0] WIDTH_CODE_12 = 2'h2;
	localparam logic [1:0] WIDTH_CODE_10 = 2'h3;
	localparam int FRAME_2X_BIT = 2;
	localparam int BYTEWISE_BIT = 4;
	localparam int DDR_BIT = 5;
	localparam int ONE_LANE_BIT = 6;
	localparam logic [7:0] SERIAL_CTRL_MASK = 8'h77;
	localparam int OVR_ENABLE_BIT = 6;
	localparam int OVR_RES_LSB = 4;
	localparam int OVR_RES_MSB = 5;
	localparam int OVR_RATE_LSB = 0;
	localparam int OVR_RATE_MSB = 2;
	localparam logic [7:0] OVERRIDE_MASK = 8'h77;
	localparam int TRANSFER_BIT = 0;
	localparam int PULLDOWN_OFF_BIT = 0;
	localparam int CM_POWERDOWN_BIT = 3;

	// ----------------------------------------------------------------
	// Serial control port framing
	// ----------------------------------------------------------------
	localparam logic [4:0] INSTR_LAST_BIT = 5'd15;
	localparam logic [4:0] DATA_LAST_BIT = 5'd7;
	// Pin order in the synchroniser: {sclk, csb, sdio}
	localparam logic [2:0] PIN_RESET = 3'h2;

	// ----------------------------------------------------------------
	// Serial output timing, in clk_i cycles
	// ----------------------------------------------------------------
	localparam logic [2:0] SLOT_LAST = 3'd5;
	localparam logic [2:0] SDR_HIGH_SLOTS = 3'd3;
	localparam logic [4:0] STEP_DDR = 5'd2;
	localparam logic [4:0] STEP_SDR = 5'd1;
	localparam int DCO_LINE = 22;
	localparam logic [3:0] SLOTS_12_TWO = 4'd6;
	localparam logic [3:0] SLOTS_10_TWO = 4'd5;
	localparam logic [3:0] SLOTS_12_ONE = 4'd12;
	localparam logic [3:0] SLOTS_10_ONE = 4'd10;

	typedef enum logic {SP_INSTR, SP_DATA} aso_spi_e;

endpackage

// File: hw/aso_serial_out.sv
`timescale 1ns/1ps

// What this block does
// - With a divider ratio above zero and an input phase no higher than the ratio, the sampling strobe fires once every ratio+1 input clocks.
// - The input phase field delays the strobe by its value in input clocks, reset value 000.
// - The input phase field only matters while the divider is in use.
// - The output clock phase field shifts the data clock by 60 degrees per code, up to code 1011.
// - The output clock phase resets to code 0011, 180 degrees from the data edges.
// - Serialization bits 1:0 choose 12-bit (10) or 10-bit (11) words.
// - In two-lane modes bit 5 picks DDR or SDR and bit 4 picks bytewise or bitwise splitting.
// - Bit 2 picks the double-length frame, and bit 6 with bit 5 clear picks one-lane DDR.
// - The serialization register resets to 0x32.
// - The override register lets software lower resolution and rate capability.
// - Override values only take effect when 1 is written to transfer bit 0.
// - The override never changes the actual sampling rate.
// - Setting bit 0 at 0x101 disables the data pin pull-down.
// - Setting bit 3 at 0x102 powers down the common-mode generator.
// - All registers but the override take effect as soon as written.
module aso_serial_out import aso_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_csb_i,
	input wire logic spi_sdio_i,
	output logic spi_sdio_o,
	output logic spi_sdio_oe_o,
	input wire logic [2:0] clock_divide_ratio_i,
	input wire logic [11:0] sample_data_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	output logic sample_strobe_o,
	input wire logic rx_ready_i,
	output logic lane_zero_pair_o,
	output logic lane_one_pair_o,
	output logic frame_o,
	output logic data_clock_output_o,
	output logic override_enable_o,
	output logic [1:0] override_resolution_o,
	output logic [2:0] override_rate_o,
	output logic sdio_pulldown_enable_o,
	output logic common_mode_generator_powerdown_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pin_s1, pin_s2, pin_s3, pin_q, pin_prev;
	logic sclk_q, csb_q, sdio_q, sclk_rise, sclk_fall;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1 <= PIN_RESET;
			pin_s2 <= PIN_RESET;
			pin_s3 <= PIN_RESET;
			pin_q <= PIN_RESET;
			pin_prev <= PIN_RESET;
		end else begin
			pin_s1 <= {spi_sclk_i, spi_csb_i, spi_sdio_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// A change only counts once the second and third stage agree
			pin_q <= ((pin_s2 ~^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_q);
			pin_prev <= pin_q;
		end
	end

	assign sclk_q = pin_q[2];
	assign csb_q = pin_q[1];
	assign sdio_q = pin_q[0];
	assign sclk_rise = sclk_q & ~pin_prev[2] & ~csb_q;
	assign sclk_fall = ~sclk_q & pin_prev[2] & ~csb_q;

	// ----------------------------------------------------------------
	// Serial control port: 16-bit instruction, then data bytes
	// ----------------------------------------------------------------
	aso_spi_e spi_state;
	logic [4:0] bit_cnt;
	logic [14:0] instr_sr;
	logic [6:0] wdata_sr;
	logic [7:0] rdata_sr, rd_value;
	logic [12:0] addr;
	logic is_read, wr_stb;
	logic [12:0] wr_addr;
	logic [7:0] wr_data;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spi_state <= SP_INSTR;
			bit_cnt <= 5'd0;
			instr_sr <= '0;
			wdata_sr <= '0;
			addr <= '0;
			is_read <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_stb <= 1'b0;
			if (csb_q) begin
				spi_state <= SP_INSTR;
				bit_cnt <= 5'd0;
			end else if (sclk_rise) begin
				case (spi_state)
					SP_INSTR: begin
						instr_sr <= {instr_sr[13:0], sdio_q};
						bit_cnt <= bit_cnt + 5'd1;
						if (bit_cnt == INSTR_LAST_BIT) begin
							spi_state <= SP_DATA;
							bit_cnt <= 5'd0;
							is_read <= instr_sr[14];
							addr <= {instr_sr[11:0], sdio_q};
						end
					end
					SP_DATA: begin
						wdata_sr <= {wdata_sr[5:0], sdio_q};
						bit_cnt <= bit_cnt + 5'd1;
						if (bit_cnt == DATA_LAST_BIT) begin
							// Streaming: each further byte goes to the next address
							bit_cnt <= 5'd0;
							addr <= addr + 13'd1;
							wr_stb <= ~is_read;
							wr_addr <= addr;
							wr_data <= {wdata_sr, sdio_q};
						end
					end
					default: begin
						spi_state <= SP_INSTR;
					end
				endcase
			end
		end
	end

	// Read data leaves on falling sclk edges, MSB first
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_sr <= '0;
		end else if (sclk_fall && spi_state == SP_DATA && is_read) begin
			if (bit_cnt == 5'd0) begin
				rdata_sr <= rd_value;
			end else begin
				rdata_sr <= {rdata_sr[6:0], 1'b0};
			end
		end
	end

	assign spi_sdio_o = rdata_sr[7];
	assign spi_sdio_oe_o = ~csb_q & is_read & (spi_state == SP_DATA);

	// ----------------------------------------------------------------
	// Register bank
	// ----------------------------------------------------------------
	logic [7:0] clock_phase_adjust, serialization_control;
	logic [7:0] override_shadow, override_active;
	logic [7:0] io_control_pulldown, io_control_common_mode;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clock_phase_adjust <= RST_CLOCK_PHASE;
			serialization_control <= RST_SERIAL_CTRL;
			io_control_pulldown <= RST_IO_PULLDOWN;
			io_control_common_mode <= RST_IO_COMMON_MODE;
		end else if (wr_stb) begin
			// Applied on the write itself, no transfer needed
			case (wr_addr)
				ADDR_CLOCK_PHASE: clock_phase_adjust <= {1'b0, wr_data[6:0]};
				ADDR_SERIAL_CTRL: serialization_control <= wr_data & SERIAL_CTRL_MASK;
				ADDR_IO_PULLDOWN: io_control_pulldown <= {7'h00, wr_data[PULLDOWN_OFF_BIT]};
				ADDR_IO_COMMON_MODE: begin
					io_control_common_mode <= {4'h0, wr_data[CM_POWERDOWN_BIT], 3'h0};
				end
				default: begin
				end
			endcase
		end
	end

	// Override is double buffered so rate and resolution switch in one step
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			override_shadow <= RST_OVERRIDE;
			override_active <= RST_OVERRIDE;
		end else if (wr_stb) begin
			if (wr_addr == ADDR_OVERRIDE) begin
				override_shadow <= wr_data & OVERRIDE_MASK;
			end
			if (wr_addr == ADDR_TRANSFER && wr_data[TRANSFER_BIT]) begin
				override_active <= override_shadow;
			end
		end
	end

	always_comb begin
		case (addr)
			ADDR_CLOCK_PHASE: rd_value = clock_phase_adjust;
			ADDR_SERIAL_CTRL: rd_value = serialization_control;
			ADDR_OVERRIDE: rd_value = override_shadow;
			ADDR_IO_PULLDOWN: rd_value = io_control_pulldown;
			ADDR_IO_COMMON_MODE: rd_value = io_control_common_mode;
			default: rd_value = 8'h00;
		endcase
	end

	// Capability only; the sampling strobe below never looks at these
	assign override_enable_o = override_active[OVR_ENABLE_BIT];
	assign override_resolution_o = override_active[OVR_RES_MSB:OVR_RES_LSB];
	assign override_rate_o = override_active[OVR_RATE_MSB:OVR_RATE_LSB];
	assign sdio_pulldown_enable_o = ~io_control_pulldown[PULLDOWN_OFF_BIT];
	assign common_mode_generator_powerdown_o = io_control_common_mode[CM_POWERDOWN_BIT];

	// ----------------------------------------------------------------
	// Sampling clock divider
	// ----------------------------------------------------------------
	logic [2:0] div_cnt, in_phase;

	assign in_phase = clock_phase_adjust[IN_PHASE_MSB:IN_PHASE_LSB];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt <= 3'd0;
		end else if (div_cnt >= clock_divide_ratio_i) begin
			div_cnt <= 3'd0;
		end else begin
			div_cnt <= div_cnt + 3'd1;
		end
	end

	// With a nonzero ratio, a phase above the ratio would never match and stall sampling
	assign sample_strobe_o = (clock_divide_ratio_i == 3'd0) ? 1'b1 :
		(div_cnt == in_phase);

	// ----------------------------------------------------------------
	// Two-entry buffer between sampling and serializer
	// ----------------------------------------------------------------
	logic [11:0] buf_mem [0:1];
	logic buf_wr_ptr, buf_rd_ptr, buf_push, buf_pop;
	logic [1:0] buf_count;

	assign sample_ready_o = (buf_count != 2'd2);
	assign buf_push = sample_valid_i & sample_strobe_o & sample_ready_o;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_wr_ptr <= 1'b0;
			buf_rd_ptr <= 1'b0;
			buf_count <= 2'd0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			if (buf_push) begin
				buf_mem[buf_wr_ptr] <= sample_data_i;
				buf_wr_ptr <= ~buf_wr_ptr;
			end
			if (buf_pop) begin
				buf_rd_ptr <= ~buf_rd_ptr;
			end
			buf_count <= buf_count + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// ----------------------------------------------------------------
	// Serializer mode decode
	// ----------------------------------------------------------------
	logic w12, one_lane, ddr, bytewise, frame2x;
	logic [3:0] slots;

	assign w12 = serialization_control[WIDTH_MSB:WIDTH_LSB] != WIDTH_CODE_10;
	assign one_lane = serialization_control[ONE_LANE_BIT] & ~serialization_control[DDR_BIT];
	assign ddr = serialization_control[DDR_BIT] | one_lane;
	assign bytewise = serialization_control[BYTEWISE_BIT];
	assign frame2x = serialization_control[FRAME_2X_BIT];
	assign slots = one_lane ? (w12 ? SLOTS_12_ONE : SLOTS_10_ONE) :
		(w12 ? SLOTS_12_TWO : SLOTS_10_TWO);

	// ----------------------------------------------------------------
	// Serializer: one bit per lane per slot of six cycles
	// ----------------------------------------------------------------
	logic [2:0] slot_cnt;
	logic [3:0] slot_idx, idx0, idx1;
	logic [11:0] word_msb, load_word;
	logic active, pair_first, slot_end;
	logic lane0_q, lane1_q, frame_q;

	assign slot_end = (slot_cnt == SLOT_LAST);
	assign buf_pop = slot_end & (~active | (slot_idx == slots - 4'd1)) &
		(buf_count != 2'd0) & rx_ready_i;

	// Stored bit-reversed so index 0 is the MSB; 10-bit drops the two LSBs
	always_comb begin
		load_word = '0;
		for (int i = 0; i < 12; i++) begin
			load_word[i] = buf_mem[buf_rd_ptr][11 - i];
		end
		if (!w12) begin
			load_word[11:10] = 2'b00;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slot_cnt <= 3'd0;
			slot_idx <= 4'd0;
			active <= 1'b0;
			pair_first <= 1'b0;
			word_msb <= '0;
		end else begin
			slot_cnt <= slot_end ? 3'd0 : slot_cnt + 3'd1;
			if (slot_end) begin
				if (active && slot_idx != slots - 4'd1) begin
					slot_idx <= slot_idx + 4'd1;
				end else if (buf_pop) begin
					word_msb <= load_word;
					slot_idx <= 4'd0;
					active <= 1'b1;
					pair_first <= ~pair_first | ~frame2x;
				end else begin
					// Receiver stall or no data: the word waits in the buffer
					active <= 1'b0;
					slot_idx <= 4'd0;
				end
			end
		end
	end

	assign idx0 = (!one_lane && !bytewise) ? {slot_idx[2:0], 1'b0} : slot_idx;
	assign idx1 = bytewise ? slot_idx + slots : {slot_idx[2:0], 1'b1};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lane0_q <= 1'b0;
			lane1_q <= 1'b0;
			frame_q <= 1'b0;
			lane_zero_pair_o <= 1'b0;
			lane_one_pair_o <= 1'b0;
			frame_o <= 1'b0;
		end else begin
			if (slot_cnt == 3'd0) begin
				lane0_q <= active & word_msb[idx0];
				lane1_q <= active & ~one_lane & word_msb[idx1];
				frame_q <= active & (frame2x ? pair_first : (slot_idx < {1'b0, slots[3:1]}));
			end
			// Extra stage matches the registered clock tap below
			lane_zero_pair_o <= lane0_q;
			lane_one_pair_o <= lane1_q;
			frame_o <= frame_q;
		end
	end

	// ----------------------------------------------------------------
	// Data clock output with programmable phase
	// ----------------------------------------------------------------
	logic dco_ref;
	logic [DCO_LINE-1:0] dco_line;
	logic [3:0] out_phase;
	logic [4:0] tap;

	assign out_phase = (clock_phase_adjust[OUT_PHASE_MSB:OUT_PHASE_LSB] > OUT_PHASE_MAX) ?
		OUT_PHASE_MAX : clock_phase_adjust[OUT_PHASE_MSB:OUT_PHASE_LSB];
	// DDR period is two slots, SDR one, so 60 degrees is two or one cycle
	assign tap = 5'(out_phase * (ddr ? STEP_DDR : STEP_SDR));

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dco_ref <= 1'b0;
			dco_line <= '0;
			data_clock_output_o <= 1'b0;
		end else begin
			if (ddr) begin
				dco_ref <= (slot_cnt == 3'd0) ? ~dco_ref : dco_ref;
			end else begin
				dco_ref <= slot_cnt < SDR_HIGH_SLOTS;
			end
			dco_line <= {dco_line[DCO_LINE-2:0], dco_ref};
			data_clock_output_o <= (tap == 5'd0) ? dco_ref : dco_line[tap - 5'd1];
		end
	end

endmodule

// File: sim/aso_rx_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Capture receiver for two-lane bytewise words
// ----------------------------------------------------------------
module aso_rx_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	input wire logic [2:0] half_i,
	input wire logic lane0_i,
	input wire logic lane1_i,
	input wire logic frame_i,
	output logic rx_ready_o,
	output logic [11:0] word_o,
	output logic word_valid_o
);
	logic frame_q;
	logic [2:0] ph;
	logic [2:0] cnt;
	logic [5:0] hi;
	logic [5:0] lo;

	assign rx_ready_o = !stall_i;

	// Sample mid-slot, so a lane edge on either side is never caught
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_q <= 1'b0;
			ph <= 3'd0;
			cnt <= 3'd0;
			hi <= 6'h00;
			lo <= 6'h00;
			word_o <= 12'h000;
			word_valid_o <= 1'b0;
		end else begin
			frame_q <= frame_i;
			word_valid_o <= 1'b0;
			ph <= (ph == 3'd5) ? 3'd0 : ph + 3'd1;
			if (frame_i && !frame_q) begin
				ph <= 3'd1;
				cnt <= 3'd1;
			end else if (cnt != 3'd0 && ph == 3'd3) begin
				hi <= {hi[4:0], lane0_i};
				lo <= {lo[4:0], lane1_i};
				cnt <= (cnt == half_i) ? 3'd0 : cnt + 3'd1;
				if (cnt == half_i) begin
					word_valid_o <= 1'b1;
					word_o <= (half_i == 3'd6) ? {hi[4:0], lane0_i, lo[4:0], lane1_i}
						: {hi[3:0], lane0_i, lo[3:0], lane1_i, 2'b00};
				end
			end
		end
	end
endmodule

// File: sim/aso_serial_out_asserts.sv
`timescale 1ns/1ps

module aso_serial_out_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic spi_csb_i,
	input wire logic [2:0] clock_divide_ratio_i,
	input wire logic sample_valid_i,
	input wire logic sample_ready_o,
	input wire logic sample_strobe_o,
	input wire logic lane_zero_pair_o,
	input wire logic frame_o,
	input wire logic data_clock_output_o,
	input wire logic override_enable_o,
	input wire logic [1:0] override_resolution_o,
	input wire logic [2:0] override_rate_o,
	input wire logic sdio_pulldown_enable_o,
	input wire logic common_mode_generator_powerdown_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_strobe_bypass;
		clock_divide_ratio_i == 3'h0 |-> sample_strobe_o;
	endproperty
	a_strobe_bypass: assert property (p_strobe_bypass)
		else $error("strobe missing with divider bypassed");

	// Phase writes land while the port is selected, so only quiet spans are judged
	property p_strobe_period;
		(spi_csb_i && clock_divide_ratio_i == 3'h3) [*5] ##0 sample_strobe_o
			|-> $past(sample_strobe_o, 4) && !$past(sample_strobe_o);
	endproperty
	a_strobe_period: assert property (p_strobe_period)
		else $error("strobe spacing differs from divide ratio");

	property p_sample_push;
		$fell(sample_ready_o) |-> $past(sample_valid_i && sample_strobe_o);
	endproperty
	a_sample_push: assert property (p_sample_push)
		else $error("buffer filled without a sampling instant");

	property p_ovr_hold;
		spi_csb_i [*8] |=> $stable({override_enable_o, override_resolution_o, override_rate_o});
	endproperty
	a_ovr_hold: assert property (p_ovr_hold)
		else $error("override outputs moved without a transfer");

	property p_io_hold;
		spi_csb_i [*8] |=> $stable({sdio_pulldown_enable_o, common_mode_generator_powerdown_o});
	endproperty
	a_io_hold: assert property (p_io_hold)
		else $error("control outputs moved without a write");

	property p_lane_slot;
		spi_csb_i && $changed(lane_zero_pair_o) |=> $stable(lane_zero_pair_o) [*5];
	endproperty
	a_lane_slot: assert property (p_lane_slot)
		else $error("lane bit shorter than one slot");

	property p_frame_slot;
		spi_csb_i && $changed(frame_o) |=> (!$changed(lane_zero_pair_o)) [*5];
	endproperty
	a_frame_slot: assert property (p_frame_slot)
		else $error("frame edge not on a slot boundary");

	property p_dco_slot;
		spi_csb_i && $changed(data_clock_output_o) |=> $stable(data_clock_output_o) [*2];
	endproperty
	a_dco_slot: assert property (p_dco_slot)
		else $error("data clock level shorter than three cycles");
endmodule

bind aso_serial_out aso_serial_out_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.spi_csb_i(spi_csb_i), .clock_divide_ratio_i(clock_divide_ratio_i),
	.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
	.sample_strobe_o(sample_strobe_o), .lane_zero_pair_o(lane_zero_pair_o), .frame_o(frame_o),
	.data_clock_output_o(data_clock_output_o), .override_enable_o(override_enable_o),
	.override_resolution_o(override_resolution_o), .override_rate_o(override_rate_o),
	.sdio_pulldown_enable_o(sdio_pulldown_enable_o),
	.common_mode_generator_powerdown_o(common_mode_generator_powerdown_o));

// File: sim/test_aso_serial_out.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module test_aso_serial_out import aso_pkg::*;;
	logic clk_i = 0, rst_n_i = 0, sclk = 0, csb = 1, sdio_h = 0, host_oe = 1;
	logic valid = 0, stall = 0, collect = 0;
	logic [2:0] ratio = 3'h0, half = 3'd6;
	logic [11:0] data = 12'h000;
	wire sdio_o, sdio_oe, ready, strobe, l0, l1, frm, data_clock_output, rxr, wv, ovr_en, pd_en, cm_pd;
	wire [1:0] ovr_res;
	wire [2:0] ovr_rate;
	wire [11:0] word;
	wire sdio_w = sdio_oe ? sdio_o : host_oe ? sdio_h : !pd_en;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	logic [11:0] got_q[$];
	logic [12:0] ra[5] = '{ADDR_CLOCK_PHASE, ADDR_SERIAL_CTRL, ADDR_OVERRIDE,
		ADDR_IO_PULLDOWN, ADDR_IO_COMMON_MODE};
	logic [7:0] rv[5] = '{8'h03, 8'h32, 8'h00, 8'h00, 8'h00};
	logic [7:0] modes[18] = '{8'h32, 8'h22, 8'h12, 8'h02, 8'h36, 8'h26, 8'h16, 8'h06, 8'h42,
		8'h33, 8'h23, 8'h13, 8'h03, 8'h37, 8'h27, 8'h17, 8'h07, 8'h43};
	logic [11:0] w[6] = '{12'ha5c, 12'h3c1, 12'hfff, 12'h801, 12'h7fe, 12'h2d9};

	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) cyc++;
	always @(posedge clk_i) if (wv === 1'b1 && collect) got_q.push_back(word);

	aso_serial_out dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_csb_i(csb),
		.spi_sdio_i(sdio_w), .spi_sdio_o(sdio_o), .spi_sdio_oe_o(sdio_oe),
		.clock_divide_ratio_i(ratio), .sample_data_i(data), .sample_valid_i(valid),
		.sample_ready_o(ready), .sample_strobe_o(strobe), .rx_ready_i(rxr),
		.lane_zero_pair_o(l0), .lane_one_pair_o(l1), .frame_o(frm),
		.data_clock_output_o(data_clock_output), .override_enable_o(ovr_en),
		.override_resolution_o(ovr_res), .override_rate_o(ovr_rate),
		.sdio_pulldown_enable_o(pd_en), .common_mode_generator_powerdown_o(cm_pd));

	aso_rx_model u_rx (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .half_i(half),
		.lane0_i(l0), .lane1_i(l1), .frame_i(frm), .rx_ready_o(rxr), .word_o(word),
		.word_valid_o(wv));

	// ----------------------------------------------------------------
	// Serial control port, eight cycles per clock half
	// ----------------------------------------------------------------
	task automatic bitx(input logic b, output logic s);
		sclk <= 0;
		sdio_h <= b;
		repeat (8) @(negedge clk_i);
		sclk <= 1;
		s = sdio_w;
		repeat (8) @(negedge clk_i);
	endtask

	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] ins;
		logic s;
		ins = {rd, 2'b00, a};
		csb <= 0;
		repeat (8) @(negedge clk_i);
		for (int i = 15; i >= 0; i--) bitx(ins[i], s);
		host_oe <= !rd;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], s);
			q[i] = s;
		end
		sclk <= 0;
		repeat (8) @(negedge clk_i);
		csb <= 1;
		host_oe <= 1;
		repeat (8) @(negedge clk_i);
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b0, a, d, q);
	endtask

	task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b1, a, 8'h00, q);
		`CHK("register", e, q)
	endtask

	task automatic count_strobes(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge clk_i);
			c += (strobe === 1'b1);
		end
	endtask

	task automatic strobe_at(output int p);
		int k;
		k = 0;
		while (strobe !== 1'b1 && k < 20) begin
			@(negedge clk_i);
			k++;
		end
		p = cyc % 4;
	endtask

	// Valid stays up between words, so back-to-back pushes never double-drive it
	task automatic push(input logic [11:0] d);
		int k;
		k = 0;
		data <= d;
		valid <= 1;
		while (!(strobe === 1'b1 && ready === 1'b1) && k < 400) begin
			@(negedge clk_i);
			k++;
		end
		@(negedge clk_i);
	endtask

	task automatic wait_words(input int n);
		int k;
		k = 0;
		while (got_q.size() < n && k < 1000) begin
			@(negedge clk_i);
			k++;
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		n_mismatch++;
		final_report;
	end

	initial begin
		int p0, p1, c;
		repeat (10) @(negedge clk_i);
		rst_n_i <= 1;
		repeat (8) @(negedge clk_i);
		foreach (ra[i]) rdchk(ra[i], rv[i]);
		`CHK("pulldown_en", 1'b1, pd_en)
		// Bit 7 of the clock phase register is not stored and reads back as zero
		wr(ADDR_CLOCK_PHASE, 8'h8f);
		rdchk(ADDR_CLOCK_PHASE, 8'h0f);
		rdchk(ADDR_TRANSFER, 8'h00);
		wr(13'h050, 8'h5a);
		rdchk(13'h050, 8'h00);
		$display("test registers done");
		wr(ADDR_IO_PULLDOWN, 8'h01);
		`CHK("pulldown_en", 1'b0, pd_en)
		rdchk(ADDR_IO_PULLDOWN, 8'h01);
		wr(ADDR_IO_PULLDOWN, 8'h00);
		wr(ADDR_IO_COMMON_MODE, 8'h08);
		`CHK("cm_powerdown", 1'b1, cm_pd)
		wr(ADDR_IO_COMMON_MODE, 8'h00);
		`CHK("cm_powerdown", 1'b0, cm_pd)
		wr(ADDR_OVERRIDE, 8'h75);
		`CHK("ovr_en", 1'b0, ovr_en)
		rdchk(ADDR_OVERRIDE, 8'h75);
		wr(ADDR_TRANSFER, 8'h01);
		`CHK("override", 6'h3d, {ovr_en, ovr_res, ovr_rate})
		$display("test controls done");
		wr(ADDR_CLOCK_PHASE, 8'h03);
		ratio <= 3'h3;
		repeat (8) @(negedge clk_i);
		strobe_at(p0);
		wr(ADDR_CLOCK_PHASE, 8'h23);
		strobe_at(p1);
		`CHK("phase", (p0 + 2) % 4, p1)
		count_strobes(40, c);
		`CHK("strobes", 10, c)
		wr(ADDR_CLOCK_PHASE, 8'h03);
		ratio <= 3'h0;
		count_strobes(16, c);
		`CHK("strobes", 16, c)
		ratio <= 3'h3;
		$display("test sampling done");
		data <= 12'ha5c;
		valid <= 1;
		foreach (modes[i]) begin
			wr(ADDR_SERIAL_CTRL, modes[i]);
			rdchk(ADDR_SERIAL_CTRL, modes[i]);
		end
		valid <= 0;
		wr(ADDR_SERIAL_CTRL, 8'h32);
		repeat (200) @(negedge clk_i);
		collect <= 1;
		stall <= 1;
		push(w[0]);
		push(w[1]);
		valid <= 0;
		repeat (40) @(negedge clk_i);
		`CHK("ready", 1'b0, ready)
		stall <= 0;
		push(w[2]);
		push(w[3]);
		valid <= 0;
		wait_words(4);
		for (int i = 0; i < 4; i++) `CHK("word", w[i], got_q[i])
		wr(ADDR_SERIAL_CTRL, 8'h33);
		half <= 3'd5;
		got_q.delete();
		push(w[4]);
		push(w[5]);
		valid <= 0;
		wait_words(2);
		for (int i = 0; i < 2; i++) `CHK("word10", {w[i + 4][11:2], 2'b00}, got_q[i])
		$display("test stream done");
		final_report;
	end
endmodule
